// *** pkg/tcpwm_pkg.sv ***
// tcpwm_pkg: constants, register map and carrier types of the
// three-phase center-based pwm timing unit.
// assumes a 32-bit avalon-mm register bus with byte addresses.
package tcpwm_pkg;

   // counter and field widths
   localparam int CNT_W = 16;
   localparam int DEAD_W = 10;
   localparam int SYNCW_W = 8;
   localparam int ADDR_W = 8;
   localparam int BOOT_W = 18;

   // register byte offsets
   localparam logic [7:0] OFS_DUTY_A = 8'h00;
   localparam logic [7:0] OFS_DUTY_B = 8'h04;
   localparam logic [7:0] OFS_DUTY_C = 8'h08;
   localparam logic [7:0] OFS_HALF_PERIOD = 8'h0c;
   localparam logic [7:0] OFS_DEAD_TIME = 8'h10;
   localparam logic [7:0] OFS_MIN_PULSE = 8'h14;
   localparam logic [7:0] OFS_SYNC_WIDTH = 8'h18;
   localparam logic [7:0] OFS_MODE_CONTROL = 8'h1c;
   localparam logic [7:0] OFS_SYSTEM_STATUS = 8'h20;

   // field positions
   localparam int MODE_DOUBLE_BIT = 6;
   localparam int STAT_HALF_BIT = 3;

   // reset values
   localparam logic [15:0] DUTY_RST = 16'h0000;
   localparam logic [15:0] HALF_PERIOD_RST = 16'h0000;
   localparam logic [9:0] DEAD_TIME_RST = 10'h000;
   localparam logic [15:0] MIN_PULSE_RST = 16'h0000;
   localparam logic [7:0] SYNC_WIDTH_RST = 8'h27;

   // first-sync delay in single mode is period plus half of it
   localparam int START_HALF_SHIFT = 1;

   // values latched into the timing unit at each sync rising edge
   typedef struct packed {
      logic [15:0] half_period;
      logic [9:0] dead_time;
      logic [15:0] min_pulse;
      logic [7:0] sync_width;
      logic [15:0] duty_a;
      logic [15:0] duty_b;
      logic [15:0] duty_c;
   } tcpwm_shadow_type;

   // one complementary output pair
   typedef struct packed {
      logic high;
      logic low;
   } tcpwm_pair_type;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_ARMED = 2'b01,
      ST_RUN = 2'b10
   } tcpwm_state_type;

endpackage

// *** hdl/tcpwm_sync_gen.sv ***
// tcpwm_sync_gen: stretches a one-cycle start strobe into the period
// sync pulse of programmable width.
// assumes start strobes come from the timing unit on ref_clk.
`timescale 1ns/1ps
module tcpwm_sync_gen
   import tcpwm_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // start strobe and live width register
   input wire logic start,
   input wire logic [SYNCW_W-1:0] width,
   // pulse out
   output logic pulse
);

   logic [SYNCW_W:0] left_reg;
   logic [SYNCW_W:0] left_next;
   logic pulse_reg;
   logic [SYNCW_W+1:0] len_reg;
   logic [SYNCW_W:0] wexp_reg;

   // reload on every start; a short period simply restarts the pulse
   assign left_next = start ? ({1'b0, width} + {{SYNCW_W{1'b0}}, 1'b1})
      : (left_reg != '0) ? left_reg - {{SYNCW_W{1'b0}}, 1'b1} : '0;

   // pulse is high for width plus one cycles
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         left_reg <= '0;
         pulse_reg <= 1'b0;
      end else begin
         left_reg <= left_next;
         pulse_reg <= (left_next != '0);
      end
   end

   assign pulse = pulse_reg;

   // helper: length of the current high run and its expected value
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         len_reg <= '0;
         wexp_reg <= '0;
      end else begin
         len_reg <= start ? {{SYNCW_W+1{1'b0}}, 1'b1}
            : (pulse_reg ? len_reg + 1'b1 : len_reg);
         if (start) begin
            wexp_reg <= {1'b0, width};
         end
      end
   end

   AST_SYNC_WIDTH: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      $fell(pulse_reg) |-> len_reg == {1'b0, wexp_reg} + 2)
      else $error("sync pulse width differs from width plus one");

endmodule

// *** hdl/tcpwm_phase.sv ***
// tcpwm_phase: one complementary output pair of the timing unit.
// assumes cnt runs up in the first half and down in the second, and
// that the latched values stay stable within a half period.
`timescale 1ns/1ps
module tcpwm_phase
   import tcpwm_pkg::*;
#(
   parameter int W = CNT_W
)
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // timing inputs
   input wire logic en,
   input wire logic [W-1:0] cnt,
   input wire logic [W-1:0] half_period,
   input wire logic [DEAD_W-1:0] dead_time,
   input wire logic [W-1:0] min_pulse,
   input wire logic [W-1:0] duty,
   // output pair
   output tcpwm_pair_type pair
);

   logic signed [W+1:0] hi_raw;
   logic signed [W+1:0] lo_raw;
   logic [W:0] hp_x;
   logic [W:0] hi_time;
   logic [W:0] lo_time;
   logic [W:0] hi_thr;
   logic del_hi;
   logic del_lo;
   logic hi_next;
   logic lo_next;
   tcpwm_pair_type pair_reg;

   // dead-time adjusted on-times per half period
   assign hp_x = {1'b0, half_period};
   assign hi_raw = $signed({2'b00, duty})
      - $signed({{(W+2-DEAD_W){1'b0}}, dead_time});
   assign lo_raw = $signed({2'b00, half_period}) - $signed({2'b00, duty})
      - $signed({{(W+2-DEAD_W){1'b0}}, dead_time});

   // clamp between no on-time and the whole half
   assign hi_time = (hi_raw < 0) ? '0
      : (hi_raw > $signed({1'b0, hp_x})) ? hp_x : hi_raw[W:0];
   assign lo_time = (lo_raw < 0) ? '0
      : (lo_raw > $signed({1'b0, hp_x})) ? hp_x : lo_raw[W:0];

   // centred edges: high sits at the top of the up/down count, low at
   // the bottom, each edge moved inward by the dead time
   assign hi_thr = hp_x - hi_time;

   // pulses shorter than the minimum are deleted for the half
   assign del_hi = hi_time < {1'b0, min_pulse};
   assign del_lo = lo_time < {1'b0, min_pulse};

   // a deleted high wins: its low is then held fully on
   assign hi_next = en & (del_hi ? 1'b0 : del_lo ? 1'b1
      : ({1'b0, cnt} >= hi_thr));
   assign lo_next = en & (del_hi ? 1'b1 : del_lo ? 1'b0
      : ({1'b0, cnt} < lo_time));

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         pair_reg <= '0;
      end else begin
         pair_reg <= '{high: hi_next, low: lo_next};
      end
   end

   assign pair = pair_reg;

   AST_NO_OVERLAP: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      !(pair_reg.high && pair_reg.low))
      else $error("high and low outputs on together");

   AST_MIN_PULSE: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (en && del_hi) |=> (!pair_reg.high && pair_reg.low))
      else $error("short high pulse was not deleted");

endmodule

// *** hdl/tcpwm_top.sv ***
// tcpwm_top: three-phase center-based pwm timing unit with its
// avalon-mm register slave.
// assumes one 100 MHz ref_clk, synchronous active-low reset, and gate
// drivers that take the six outputs directly.
//
// What this block does
// - each duty register drives its own phase pair
// - duty is high on-time count per half
// - single mode waveforms centred in sync period
// - every edge moved equally by dead time
// - single mode on-times twice duty minus dead
// - on-times clamped between zero and full period
// - double mode on-times sum both halves
// - double mode period sums both latched periods
// - phases b and c follow phase a rules
// - no outputs until period and duties written
// - single mode first sync after 1.5 periods
// - double mode first sync after one period
// - single mode same duty in both halves
// - double mode latches duty per half
// - status bit 3 shows active half
// - minimum pulse register sets least on-time
// - short pulse off, complement fully on
// - period register counts half a period
// - mode bit 6 selects double update
// - sync rising edge latches all settings
// - sync pulse width is register plus one
`timescale 1ns/1ps
module tcpwm_top
   import tcpwm_pkg::*;
(
   // clock and reset
   input wire logic ref_clk,
   input wire logic rst_b,
   // avalon-mm slave
   input wire logic [ADDR_W-1:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   // gate drive outputs
   output logic phase_a_high_out,
   output logic phase_a_low_out,
   output logic phase_b_high_out,
   output logic phase_b_low_out,
   output logic phase_c_high_out,
   output logic phase_c_low_out,
   // period sync
   output logic period_sync_pulse
);

   // software-visible registers and the written flags
   logic [15:0] duty_phase_a_reg;
   logic [15:0] duty_phase_b_reg;
   logic [15:0] duty_phase_c_reg;
   logic [15:0] half_period_count_reg;
   logic [9:0] dead_time_count_reg;
   logic [15:0] min_pulse_count_reg;
   logic [7:0] sync_width_count_reg;
   logic mode_double_reg;
   logic [3:0] written_reg;
   // bus side
   logic rd_done_reg;
   logic [31:0] readdata_reg;
   logic [31:0] rd_word;
   logic [31:0] wr_word;
   logic [31:0] be_mask;
   logic wr_duty_a;
   logic wr_duty_b;
   logic wr_duty_c;
   logic wr_period;
   logic wr_dead;
   logic wr_minp;
   logic wr_syncw;
   logic wr_mode;
   // timing side
   tcpwm_state_type st_reg;
   tcpwm_state_type st_next;
   logic [BOOT_W-1:0] boot_cnt_reg;
   logic [BOOT_W-1:0] boot_load;
   tcpwm_shadow_type shadow_reg;
   tcpwm_shadow_type shadow_live;
   logic [CNT_W-1:0] cnt_reg;
   logic half_reg;
   logic all_written;
   logic go;
   logic last_up;
   logic period_end;
   logic mid;
   logic latch_now;
   logic sync_start;
   logic running;
   logic [CNT_W-1:0] mid_hp;
   tcpwm_pair_type pair_a;
   tcpwm_pair_type pair_b;
   tcpwm_pair_type pair_c;

   // byte enables widen to a bit mask; unselected lanes keep old bits
   assign be_mask = {{8{avs_byteenable[3]}}, {8{avs_byteenable[2]}},
      {8{avs_byteenable[1]}}, {8{avs_byteenable[0]}}};
   assign wr_word = (avs_writedata & be_mask) | (rd_word & ~be_mask);

   // address decode for writes; unmapped writes are dropped
   assign wr_duty_a = avs_write & (avs_address == OFS_DUTY_A);
   assign wr_duty_b = avs_write & (avs_address == OFS_DUTY_B);
   assign wr_duty_c = avs_write & (avs_address == OFS_DUTY_C);
   assign wr_period = avs_write & (avs_address == OFS_HALF_PERIOD);
   assign wr_dead = avs_write & (avs_address == OFS_DEAD_TIME);
   assign wr_minp = avs_write & (avs_address == OFS_MIN_PULSE);
   assign wr_syncw = avs_write & (avs_address == OFS_SYNC_WIDTH);
   assign wr_mode = avs_write & (avs_address == OFS_MODE_CONTROL);

   // read mux; unused bits and unmapped offsets read zero
   assign rd_word =
      (avs_address == OFS_DUTY_A) ? {16'h0000, duty_phase_a_reg} :
      (avs_address == OFS_DUTY_B) ? {16'h0000, duty_phase_b_reg} :
      (avs_address == OFS_DUTY_C) ? {16'h0000, duty_phase_c_reg} :
      (avs_address == OFS_HALF_PERIOD) ?
         {16'h0000, half_period_count_reg} :
      (avs_address == OFS_DEAD_TIME) ? {22'h0, dead_time_count_reg} :
      (avs_address == OFS_MIN_PULSE) ? {16'h0000, min_pulse_count_reg} :
      (avs_address == OFS_SYNC_WIDTH) ? {24'h000000, sync_width_count_reg} :
      (avs_address == OFS_MODE_CONTROL) ?
         (32'h0000_0001 << MODE_DOUBLE_BIT) & {32{mode_double_reg}} :
      (avs_address == OFS_SYSTEM_STATUS) ?
         (32'h0000_0001 << STAT_HALF_BIT) & {32{half_reg}} :
      32'h0000_0000;

   // writes finish at once; reads wait one cycle for registered data
   assign avs_waitrequest = avs_read & ~rd_done_reg;
   assign avs_readdata = readdata_reg;

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         rd_done_reg <= 1'b0;
         readdata_reg <= 32'h0000_0000;
      end else begin
         rd_done_reg <= avs_read & ~rd_done_reg;
         if (avs_read & ~rd_done_reg) begin
            readdata_reg <= rd_word;
         end
      end
   end

   // configuration registers; mode bit picks double update
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         duty_phase_a_reg <= DUTY_RST;
         duty_phase_b_reg <= DUTY_RST;
         duty_phase_c_reg <= DUTY_RST;
         half_period_count_reg <= HALF_PERIOD_RST;
         dead_time_count_reg <= DEAD_TIME_RST;
         min_pulse_count_reg <= MIN_PULSE_RST;
         sync_width_count_reg <= SYNC_WIDTH_RST;
         mode_double_reg <= 1'b0;
      end else begin
         if (wr_duty_a) duty_phase_a_reg <= wr_word[15:0];
         if (wr_duty_b) duty_phase_b_reg <= wr_word[15:0];
         if (wr_duty_c) duty_phase_c_reg <= wr_word[15:0];
         if (wr_period) half_period_count_reg <= wr_word[15:0];
         if (wr_dead) dead_time_count_reg <= wr_word[9:0];
         if (wr_minp) min_pulse_count_reg <= wr_word[15:0];
         if (wr_syncw) sync_width_count_reg <= wr_word[7:0];
         if (wr_mode) mode_double_reg <= wr_word[MODE_DOUBLE_BIT];
      end
   end

   // remember which of period and the three duties were ever written
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         written_reg <= 4'h0;
      end else begin
         written_reg <= written_reg
            | {wr_period, wr_duty_c, wr_duty_b, wr_duty_a};
      end
   end
   assign all_written = &written_reg;

   // start-up delay measured from the first period write; 1.5 times
   // the period in single mode (odd periods round down), once in double
   assign boot_load = mode_double_reg
      ? {2'b00, wr_word[15:0]}
      : {2'b00, wr_word[15:0]}
         + {3'b000, wr_word[15:START_HALF_SHIFT]};

   // waits for both the delay and the last duty write
   assign go = (st_reg == ST_ARMED) && (boot_cnt_reg <= 1) && all_written;

   always_comb begin
      st_next = st_reg;
      case (st_reg)
         ST_IDLE: begin
            if (wr_period) st_next = ST_ARMED;
         end
         ST_ARMED: begin
            if (go) st_next = ST_RUN;
         end
         ST_RUN: begin
            st_next = ST_RUN;
         end
         default: begin
            st_next = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         st_reg <= ST_IDLE;
         boot_cnt_reg <= '0;
      end else begin
         st_reg <= st_next;
         if (st_reg == ST_IDLE && wr_period) begin
            boot_cnt_reg <= boot_load;
         end else if (st_reg == ST_ARMED && boot_cnt_reg > 1) begin
            boot_cnt_reg <= boot_cnt_reg - 1'b1;
         end
      end
   end

   assign running = (st_reg == ST_RUN);

   // period boundaries of the up/down counter
   assign last_up = ({1'b0, cnt_reg} + 17'h00001)
      >= {1'b0, shadow_reg.half_period};
   assign period_end = running & half_reg & (cnt_reg == '0);
   assign mid = running & ~half_reg & last_up;

   // sync edges latch all; double mode also at mid
   assign latch_now = go | period_end | (mid & mode_double_reg);
   assign sync_start = latch_now;

   assign shadow_live = '{half_period: half_period_count_reg,
      dead_time: dead_time_count_reg, min_pulse: min_pulse_count_reg,
      sync_width: sync_width_count_reg, duty_a: duty_phase_a_reg,
      duty_b: duty_phase_b_reg, duty_c: duty_phase_c_reg};

   // length of the down half: the newly latched period in double mode
   assign mid_hp = mode_double_reg ? half_period_count_reg
      : shadow_reg.half_period;

   // shadow values hold a whole period in single mode
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         shadow_reg <= '0;
      end else if (latch_now) begin
         shadow_reg <= shadow_live;
      end
   end

   // up through the first half, down through the second
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         cnt_reg <= '0;
         half_reg <= 1'b0;
      end else if (go | period_end) begin
         cnt_reg <= '0;
         half_reg <= 1'b0;
      end else if (mid) begin
         cnt_reg <= (mid_hp == '0) ? '0 : mid_hp - 1'b1;
         half_reg <= 1'b1;
      end else if (running) begin
         cnt_reg <= half_reg ? cnt_reg - 1'b1 : cnt_reg + 1'b1;
      end
   end

   // each pair uses the same timing from its own duty
   tcpwm_phase #(.W(CNT_W)) u_phase_a (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(running),
      .cnt(cnt_reg),
      .half_period(shadow_reg.half_period),
      .dead_time(shadow_reg.dead_time),
      .min_pulse(shadow_reg.min_pulse),
      .duty(shadow_reg.duty_a),
      .pair(pair_a)
   );

   tcpwm_phase #(.W(CNT_W)) u_phase_b (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(running),
      .cnt(cnt_reg),
      .half_period(shadow_reg.half_period),
      .dead_time(shadow_reg.dead_time),
      .min_pulse(shadow_reg.min_pulse),
      .duty(shadow_reg.duty_b),
      .pair(pair_b)
   );

   tcpwm_phase #(.W(CNT_W)) u_phase_c (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .en(running),
      .cnt(cnt_reg),
      .half_period(shadow_reg.half_period),
      .dead_time(shadow_reg.dead_time),
      .min_pulse(shadow_reg.min_pulse),
      .duty(shadow_reg.duty_c),
      .pair(pair_c)
   );

   // sync width uses the live register at the latch edge
   tcpwm_sync_gen u_sync (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .start(sync_start),
      .width(sync_width_count_reg),
      .pulse(period_sync_pulse)
   );

   // per-half sums give double mode on-times
   assign phase_a_high_out = pair_a.high;
   assign phase_a_low_out = pair_a.low;
   assign phase_b_high_out = pair_b.high;
   assign phase_b_low_out = pair_b.low;
   assign phase_c_high_out = pair_c.high;
   assign phase_c_low_out = pair_c.low;

   // helper: cycles since the first period write and the expected delay
   logic [BOOT_W-1:0] boot_seen_reg;
   logic [BOOT_W-1:0] boot_exp_reg;
   logic boot_dbl_reg;
   always_ff @(posedge ref_clk) begin
      if (!rst_b) begin
         boot_seen_reg <= '0;
         boot_exp_reg <= '0;
         boot_dbl_reg <= 1'b0;
      end else if (st_reg == ST_IDLE && wr_period) begin
         boot_seen_reg <= {{BOOT_W-1{1'b0}}, 1'b1};
         boot_exp_reg <= boot_load;
         boot_dbl_reg <= mode_double_reg;
      end else if (st_reg == ST_ARMED) begin
         boot_seen_reg <= boot_seen_reg + 1'b1;
      end
   end

   AST_NO_OUT_BEFORE_START: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (st_reg != ST_RUN) |=> !(phase_a_high_out || phase_a_low_out
         || phase_b_high_out || phase_b_low_out
         || phase_c_high_out || phase_c_low_out))
      else $error("pwm output before start-up complete");

   AST_FIRST_SYNC_SINGLE: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (st_reg == ST_ARMED && all_written && !boot_dbl_reg
         && boot_seen_reg == boot_exp_reg) |-> go ##1 period_sync_pulse)
      else $error("first sync not at 1.5 periods in single mode");

   AST_FIRST_SYNC_DOUBLE: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (st_reg == ST_ARMED && all_written && boot_dbl_reg
         && boot_seen_reg == boot_exp_reg) |-> go ##1 period_sync_pulse)
      else $error("first sync not at one period in double mode");

   AST_HALF_FLAG: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (go || period_end) |=> !half_reg ##0 ($past(mid) || !half_reg))
      else $error("half flag not cleared at period start");

   AST_COUNT_UP: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (running && !half_reg && !last_up) |=> cnt_reg == $past(cnt_reg) + 1)
      else $error("counter did not count up in first half");

   AST_NO_MID_SYNC_SINGLE: assert property (
      @(posedge ref_clk) disable iff (!rst_b)
      (mid && !mode_double_reg) |-> !sync_start ##1 half_reg)
      else $error("mid sync in single mode or half not entered");

endmodule

// *** tb/tcpwm_gate_model.sv ***
// tcpwm_gate_model: gate driver stand-in that counts the on-cycles of
// the six drive levels and of the sync pulse, and flags shoot-through.
// assumes levels are sampled on ref_clk; clr zeroes all counts.
`timescale 1ns/1ps
module tcpwm_gate_model (
   // clock and control
   input wire logic ref_clk,
   input wire logic clr,
   // sync in bit 6, then high/low pairs of phases a, b, c
   input wire logic [6:0] drive,
   // results
   output logic [6:0][7:0] on_cnt,
   output logic shoot
);
   // a leg with both switches on shorts the dc link, so it is latched
   always_ff @(posedge ref_clk) begin
      for (int i = 0; i < 7; i++) begin
         on_cnt[i] <= clr ? 8'h00 : on_cnt[i] + {7'h00, drive[i]};
      end
      shoot <= clr ? 1'b0 : shoot | (drive[5] & drive[4]) |
               (drive[3] & drive[2]) | (drive[1] & drive[0]);
   end
endmodule

// *** tb/tb_top.sv ***
// tb_top: register-driven bench of the pwm timing unit.
// assumes a 100 MHz ref_clk and the one-wait-state read of the slave.
`timescale 1ns/1ps
`define CHK(got, exp) begin n_checks++; if ((got) !== (exp)) begin \
   n_errors++; $display("[FAIL] %0t mismatch %0h %0h", $time, got, exp); \
   end end
module tb_top;
   import tcpwm_pkg::*;
   logic ref_clk = 1'b0, rst_b = 1'b0, avs_read = 1'b0, avs_write = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic [31:0] avs_writedata = 32'h0;
   logic [3:0] avs_byteenable = 4'hf;
   wire logic [31:0] avs_readdata;
   wire logic avs_waitrequest, ah, al, bh, bl, chh, cl, sync;
   wire logic [6:0][7:0] cnt;
   wire logic shoot;
   logic clr = 1'b1, sync_d = 1'b0;
   int n_errors = 0, n_checks = 0, cyc = 0, t_wr = 0;

   tcpwm_top dut (.ref_clk(ref_clk), .rst_b(rst_b),
      .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata),
      .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .phase_a_high_out(ah),
      .phase_a_low_out(al), .phase_b_high_out(bh), .phase_b_low_out(bl),
      .phase_c_high_out(chh), .phase_c_low_out(cl),
      .period_sync_pulse(sync));
   tcpwm_gate_model gate (.ref_clk(ref_clk), .clr(clr),
      .drive({sync, ah, al, bh, bl, chh, cl}), .on_cnt(cnt),
      .shoot(shoot));

   // clock, and a cycle count used to time the first sync
   always #5 ref_clk = ~ref_clk;
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      sync_d <= sync;
   end

   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("bench passed");
      end else begin
         $display("bench failed");
      end
      $finish;
   endtask

   // hold the request until waitrequest is sampled low, bounded
   task automatic wait_ack();
      int i;
      i = 0;
      do begin
         @(posedge ref_clk);
         i++;
      end while (avs_waitrequest !== 1'b0 && i < 50);
      if (avs_waitrequest !== 1'b0) begin
         n_errors++;
         complete_run();
      end
   endtask

   // one edge idles after each access so strobes are never re-driven
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= 1'b1;
      wait_ack();
      t_wr = cyc;
      avs_write <= 1'b0;
      @(posedge ref_clk);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d);
      avs_address <= a;
      avs_read <= 1'b1;
      wait_ack();
      d = avs_readdata;
      avs_read <= 1'b0;
      @(posedge ref_clk);
   endtask

   // returns at the edge where a sync rise is first sampled
   task automatic wait_sync(output int n);
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (!(sync === 1'b1 && sync_d === 1'b0) && n < 200);
      if (n >= 200) begin
         n_errors++;
         complete_run();
      end
   endtask

   // counts on-cycles over one full period of 2*t cycles
   task automatic measure(input int t, input logic [6:0][7:0] exp);
      int n;
      wait_sync(n);
      clr <= 1'b1;
      @(posedge ref_clk);
      clr <= 1'b0;
      // one extra edge: the counts are read as they stand at that edge
      repeat (2 * t + 1) @(posedge ref_clk);
      `CHK(cnt, exp)
   endtask

   initial begin
      logic [31:0] d, d2;
      int n;
      repeat (10) @(posedge ref_clk);
      rst_b <= 1'b1;
      clr <= 1'b0;
      rd(OFS_SYNC_WIDTH, d);
      `CHK(d, 32'h27)
      rd(8'h24, d);
      `CHK(d, 32'h0)
      wr(OFS_DEAD_TIME, 32'h1);
      wr(OFS_SYNC_WIDTH, 32'h2);
      wr(OFS_HALF_PERIOD, 32'h8);
      n = t_wr;
      wr(OFS_DUTY_A, 32'h5);
      wr(OFS_DUTY_B, 32'h2);
      `CHK(cnt, 56'h0)
      wr(OFS_DUTY_C, 32'h8);
      wait_sync(d2);
      `CHK(cyc - n, 13)
      // single mode: dead time, clamp to zero, per-phase duties
      measure(8, 56'h03_08_04_02_0a_0e_00);
      `CHK(shoot, 1'b0)
      // short pulses deleted, complements held fully on
      wr(OFS_MIN_PULSE, 32'h3);
      wait_sync(n);
      measure(8, 56'h03_10_00_00_10_10_00);
      wr(OFS_MIN_PULSE, 32'h0);
      wr(OFS_MODE_CONTROL, 32'h40);
      rd(OFS_MODE_CONTROL, d);
      `CHK(d[MODE_DOUBLE_BIT], 1'b1)
      wait_sync(n);
      wait_sync(n);
      wait_sync(n);
      `CHK(n, 8)
      rd(OFS_SYSTEM_STATUS, d);
      wait_sync(n);
      rd(OFS_SYSTEM_STATUS, d2);
      `CHK(d[STAT_HALF_BIT] ^ d2[STAT_HALF_BIT], 1'b1)
      // two syncs per period, on-times summed over both halves
      measure(8, 56'h06_08_04_02_0a_0e_00);
      `CHK(shoot, 1'b0)
      // mid-run reset, then a double-mode start-up: first sync after one
      // period, seen one edge later by wait_sync
      rst_b <= 1'b0;
      repeat (3) @(posedge ref_clk);
      rst_b <= 1'b1;
      wr(OFS_MODE_CONTROL, 32'h40);
      wr(OFS_HALF_PERIOD, 32'h8);
      n = t_wr;
      wr(OFS_DUTY_A, 32'h5);
      wr(OFS_DUTY_B, 32'h2);
      wr(OFS_DUTY_C, 32'h8);
      wait_sync(d2);
      `CHK(cyc - n, 9)
      complete_run();
   end
endmodule
